/* sync_burst_sram_cycle_decode.sv */
// Cycle decoder, byte-write control and storage of a pipelined burst
// SRAM with zero bus turnaround.
// Assumes the controller runs on ref_clk; sleepRequest and burstOrder are
// asynchronous levels, outputEnableN acts without the clock.
//
// Behaviour
// - Hold low, load low: deselect, read or write at external address.
// - Advance high ignores selects and strobe; burst continues, deselect stays.
// - Read with output enable high is dummy read, pins stay tristated.
// - Write begins with selects active, strobe low, some lane selected.
// - Write begun with no lanes is an abort; nothing written, pins off.
// - Continued write beat with no lanes writes nothing, address advances.
// - Clock hold high ignores the edge; cycle state is kept, but the synchronisers and sleep logic still run.
// - Data and parity pins tristated in every write data phase.
// - Pin drive follows cycle type in output phase and output enable.
// - After reset deselected with all pins tristated.
// - Output enable is combinational and masked during writes.
// - Read phase drives data only while output enable is low.
// - Strobe high is read; low writes each selected lane with parity.
// - Write data is latched on the second edge after the address.
// - Any lane combination is valid; unselected bytes are kept.
// - Burst low bits linear or interleaved, wrapping after four beats.
// - Sleep tristates outputs; entry and exit take two cycles each.
`timescale 1ns/10ps
module sync_burst_sram_cycle_decode #(
	parameter int ADDR_W = sync_burst_sram_pkg::ADDR_W
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_n,
	input  wire sync_burst_sram_pkg::cmd_s  cmd,
	input  wire logic [ADDR_W-1:0]          address,
	input  wire logic                       clockHoldN,
	input  wire logic                       outputEnableN,
	input  wire logic                       sleepRequest,
	input  wire logic                       burstOrder,
	input  wire logic [sync_burst_sram_pkg::PARITY_LSB-1:0] dataIn,
	output logic      [sync_burst_sram_pkg::PARITY_LSB-1:0] dataOut,
	output logic                            dataOe,
	input  wire logic [sync_burst_sram_pkg::LANES-1:0]      byteParityLinesIn,
	output logic      [sync_burst_sram_pkg::LANES-1:0]      byteParityLinesOut,
	output logic                            byteParityLinesOe,
	output logic                            sleeping
);

	localparam int LANES  = sync_burst_sram_pkg::LANES;
	localparam int LW     = sync_burst_sram_pkg::LANE_DATA_W;
	localparam int WW     = sync_burst_sram_pkg::WORD_W;
	localparam int PL     = sync_burst_sram_pkg::PARITY_LSB;
	localparam int BW     = sync_burst_sram_pkg::BURST_W;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [WW-1:0]              mem [0:(1<<ADDR_W)-1];
	logic                       sleepMeta;
	logic                       sleepSync;
	logic                       orderMeta;
	logic                       burstOrderQ;
	sync_burst_sram_pkg::sleep_e stateQ;
	logic [sync_burst_sram_pkg::SLEEP_CNT_W-1:0] sleepCntQ;
	sync_burst_sram_pkg::op_e   kindQ;
	sync_burst_sram_pkg::op_e   op1Q;
	sync_burst_sram_pkg::op_e   op2Q;
	logic [ADDR_W-1:0]          baseQ;
	logic [ADDR_W-1:0]          addr1Q;
	logic [ADDR_W-1:0]          addr2Q;
	logic [BW-1:0]              burstCntQ;
	logic [BW-1:0]              cntNext;
	logic [BW-1:0]              lowNext;
	logic [LANES-1:0]           lanes1Q;
	logic [LANES-1:0]           lanes2Q;
	logic [WW-1:0]              readWordQ;
	logic [WW-1:0]              inWord;
	logic [WW-1:0]              mergedWord;
	logic                       awake;
	logic                       step;
	logic                       selActive;
	logic                       anyLane;
	logic                       writeNow;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sleepMeta   <= 1'b0;
			sleepSync   <= 1'b0;
			orderMeta   <= 1'b0;
			burstOrderQ <= 1'b0;
		end else begin
			sleepMeta   <= sleepRequest;
			sleepSync   <= sleepMeta;
			orderMeta   <= burstOrder;
			burstOrderQ <= orderMeta;
		end
	end

	// ----------------------------------------------------------------
	// Sleep entry and exit
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateQ    <= sync_burst_sram_pkg::ST_AWAKE;
			sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
		end else begin
			case (stateQ)
				sync_burst_sram_pkg::ST_AWAKE: begin
					sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
					if (sleepSync)
						stateQ <= sync_burst_sram_pkg::ST_ENTER;
				end
				sync_burst_sram_pkg::ST_ENTER: begin
					sleepCntQ <= sleepCntQ + 1'b1;
					if (sleepCntQ == sync_burst_sram_pkg::SLEEP_LAST) begin
						stateQ    <= sync_burst_sram_pkg::ST_SLEEP;
						sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
					end
				end
				sync_burst_sram_pkg::ST_SLEEP: begin
					sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
					if (!sleepSync)
						stateQ <= sync_burst_sram_pkg::ST_WAKE;
				end
				sync_burst_sram_pkg::ST_WAKE: begin
					sleepCntQ <= sleepCntQ + 1'b1;
					if (sleepCntQ == sync_burst_sram_pkg::SLEEP_LAST) begin
						stateQ    <= sync_burst_sram_pkg::ST_AWAKE;
						sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
					end
				end
				default: begin
					stateQ    <= sync_burst_sram_pkg::ST_AWAKE;
					sleepCntQ <= sync_burst_sram_pkg::SLEEP_CNT_ZERO;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Cycle decode and burst address
	// ----------------------------------------------------------------
	assign awake     = (stateQ == sync_burst_sram_pkg::ST_AWAKE);
	assign step      = awake && !clockHoldN;
	assign selActive = !cmd.chipSel1N && cmd.chipSel2 && !cmd.chipSel3N;
	assign anyLane   = !(&cmd.byteLaneSelectN);
	assign cntNext   = burstCntQ + sync_burst_sram_pkg::BURST_ONE;
	assign lowNext   = burstOrderQ ? (baseQ[BW-1:0] ^ cntNext)
		: BW'(baseQ[BW-1:0] + cntNext);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			op1Q      <= sync_burst_sram_pkg::OP_DESEL;
			kindQ     <= sync_burst_sram_pkg::OP_DESEL;
			baseQ     <= '0;
			addr1Q    <= '0;
			burstCntQ <= sync_burst_sram_pkg::BURST_ZERO;
			lanes1Q   <= '0;
		end else if (!awake) begin
			op1Q  <= sync_burst_sram_pkg::OP_DESEL;
			kindQ <= sync_burst_sram_pkg::OP_DESEL;
		end else if (step) begin
			lanes1Q <= ~cmd.byteLaneSelectN;
			if (!cmd.advanceOrLoad) begin
				baseQ     <= address;
				addr1Q    <= address;
				burstCntQ <= sync_burst_sram_pkg::BURST_ZERO;
				if (!selActive) begin
					op1Q  <= sync_burst_sram_pkg::OP_DESEL;
					kindQ <= sync_burst_sram_pkg::OP_DESEL;
				end else if (cmd.writeStrobeN) begin
					op1Q  <= sync_burst_sram_pkg::OP_READ;
					kindQ <= sync_burst_sram_pkg::OP_READ;
				end else begin
					kindQ <= sync_burst_sram_pkg::OP_WRITE;
					op1Q  <= anyLane ? sync_burst_sram_pkg::OP_WRITE
						: sync_burst_sram_pkg::OP_ABORT;
				end
			end else begin
				burstCntQ <= cntNext;
				addr1Q    <= {baseQ[ADDR_W-1:BW], lowNext};
				if (kindQ == sync_burst_sram_pkg::OP_WRITE)
					op1Q <= anyLane ? sync_burst_sram_pkg::OP_WRITE
						: sync_burst_sram_pkg::OP_ABORT;
				else
					op1Q <= kindQ;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output phase stage, read data and write commit
	// ----------------------------------------------------------------
	assign inWord   = {byteParityLinesIn, dataIn};
	assign writeNow = step && (op2Q == sync_burst_sram_pkg::OP_WRITE);

	always_comb begin
		mergedWord = mem[addr1Q];
		if (writeNow && (addr2Q == addr1Q)) begin
			for (int i = 0; i < LANES; i++) begin
				if (lanes2Q[i]) begin
					mergedWord[i*LW +: LW] = inWord[i*LW +: LW];
					mergedWord[PL + i]     = inWord[PL + i];
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			op2Q      <= sync_burst_sram_pkg::OP_DESEL;
			addr2Q    <= '0;
			lanes2Q   <= '0;
			readWordQ <= '0;
		end else if (!awake) begin
			op2Q <= sync_burst_sram_pkg::OP_DESEL;
		end else if (step) begin
			op2Q    <= op1Q;
			addr2Q  <= addr1Q;
			lanes2Q <= lanes1Q;
			if (op1Q == sync_burst_sram_pkg::OP_READ)
				readWordQ <= mergedWord;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (writeNow) begin
			for (int i = 0; i < LANES; i++) begin
				if (lanes2Q[i]) begin
					mem[addr2Q][i*LW +: LW] <= inWord[i*LW +: LW];
					mem[addr2Q][PL + i]     <= inWord[PL + i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	assign dataOe = awake && (op2Q == sync_burst_sram_pkg::OP_READ)
		&& !outputEnableN;
	assign byteParityLinesOe  = dataOe;
	assign dataOut            = readWordQ[PL-1:0];
	assign byteParityLinesOut = readWordQ[WW-1:PL];
	assign sleeping           = (stateQ == sync_burst_sram_pkg::ST_SLEEP);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_deselect_tristate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		op2Q == sync_burst_sram_pkg::OP_DESEL |-> !dataOe)
		else $error("Pins driven in deselect phase");
	a_dummy_read_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		outputEnableN |-> !dataOe && !byteParityLinesOe)
		else $error("Pins driven with output enable high");
	a_write_phase_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(op2Q == sync_burst_sram_pkg::OP_WRITE
		|| op2Q == sync_burst_sram_pkg::OP_ABORT) |-> !dataOe)
		else $error("Pins driven in write data phase");
	a_read_drives: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(awake && op2Q == sync_burst_sram_pkg::OP_READ && !outputEnableN)
		|-> dataOe)
		else $error("Read phase not driven");
	a_hold_freezes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clockHoldN && awake && !sleepSync) |=> $stable(op1Q)
		&& $stable(op2Q) && $stable(addr1Q) && $stable(readWordQ))
		else $error("State changed on held edge");
	a_load_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(step && !sleepSync && !cmd.advanceOrLoad && selActive
		&& cmd.writeStrobeN) |=> op1Q == sync_burst_sram_pkg::OP_READ
		&& addr1Q == $past(address))
		else $error("Read not loaded at external address");
	a_abort_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(step && !sleepSync && !cmd.advanceOrLoad && selActive
		&& !cmd.writeStrobeN && !anyLane)
		|=> op1Q == sync_burst_sram_pkg::OP_ABORT)
		else $error("Empty write not aborted");
	a_desel_stays: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(step && !sleepSync && cmd.advanceOrLoad
		&& kindQ == sync_burst_sram_pkg::OP_DESEL)
		|=> op1Q == sync_burst_sram_pkg::OP_DESEL)
		else $error("Continued deselect left deselect");
	a_burst_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(step && !sleepSync && cmd.advanceOrLoad
		&& kindQ != sync_burst_sram_pkg::OP_DESEL) |=> addr1Q[BW-1:0] ==
		(burstOrderQ ? (baseQ[BW-1:0] ^ burstCntQ)
		: BW'(baseQ[BW-1:0] + burstCntQ)))
		else $error("Burst address out of sequence");
	a_read_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(step && !sleepSync && op1Q == sync_burst_sram_pkg::OP_READ)
		|=> op2Q == sync_burst_sram_pkg::OP_READ)
		else $error("Read did not reach output phase");
	a_sleep_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(stateQ == sync_burst_sram_pkg::ST_AWAKE && sleepSync)
		|=> !dataOe ##2 stateQ == sync_burst_sram_pkg::ST_SLEEP)
		else $error("Sleep entry not two cycles");
	a_reset_off: assert property (@(posedge ref_clk)
		!rst_n |=> !dataOe)
		else $error("Pins driven after reset");

endmodule

/* sync_burst_sram_pkg.sv */
// Shared types and constants of the burst SRAM cycle decoder.
// Assumes one clock domain and a controller on that same clock.
package sync_burst_sram_pkg;

	// ----------------------------------------------------------------
	// Geometry and timing
	// ----------------------------------------------------------------
	localparam int LANES        = 4;
	localparam int LANE_DATA_W  = 8;
	localparam int ADDR_W       = 20;
	localparam int BURST_W      = 2;
	localparam int SLEEP_CYCLES = 2;
	localparam int SLEEP_CNT_W  = 2;
	localparam int WORD_W       = LANES * (LANE_DATA_W + 1);
	localparam int PARITY_LSB   = LANES * LANE_DATA_W;

	localparam logic [SLEEP_CNT_W-1:0] SLEEP_LAST =
		SLEEP_CNT_W'(SLEEP_CYCLES - 1);
	localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT_ZERO = '0;
	localparam logic [BURST_W-1:0]     BURST_ZERO     = '0;
	localparam logic [BURST_W-1:0]     BURST_ONE      = BURST_W'(1);

	// ----------------------------------------------------------------
	// Cycle types and sleep states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_DESEL = 4'h1,
		OP_READ  = 4'h2,
		OP_WRITE = 4'h4,
		OP_ABORT = 4'h8
	} op_e;

	typedef enum logic [3:0] {
		ST_AWAKE = 4'h1,
		ST_ENTER = 4'h2,
		ST_SLEEP = 4'h4,
		ST_WAKE  = 4'h8
	} sleep_e;

	// ----------------------------------------------------------------
	// Controller command bundle, sampled each rising edge with clock hold low while awake
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             chipSel1N;
		logic             chipSel2;
		logic             chipSel3N;
		logic             advanceOrLoad;
		logic             writeStrobeN;
		logic [LANES-1:0] byteLaneSelectN;
	} cmd_s;

endpackage

/* sram_ctrl_model.sv */
// Memory controller model: drives commands and write data, checks reads.
// Assumes tb_top provides the check task and the expected words.
`timescale 1ns/10ps
module sram_ctrl_model (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	output sync_burst_sram_pkg::cmd_s      cmd,
	output logic [7:0]                     address,
	output logic                           clockHoldN,
	output logic [31:0]                    dataIn,
	output logic [3:0]                     byteParityLinesIn,
	input  wire logic [31:0]               dataOut,
	input  wire logic [3:0]                byteParityLinesOut,
	input  wire logic                      dataOe,
	input  wire logic                      byteParityLinesOe,
	input  wire logic                      outputEnableN
);
	// ------------------------------------------------------------
	// Command issue and data phase tracking
	// ------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [35:0] word;
	} beat_s;

	beat_s pinBeat, s1, s2;

	initial begin
		cmd = 9'h10f;
		address = 8'h00;
		clockHoldN = 1'b0;
		{byteParityLinesIn, dataIn} = 36'h0;
		pinBeat = '0;
	end

	task automatic issue(input sync_burst_sram_pkg::cmd_s c,
		input logic [7:0] a, input logic hold, input beat_s b);
		@(posedge ref_clk);
		cmd <= c;
		address <= a;
		clockHoldN <= hold;
		pinBeat <= b;
	endtask

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
		end else if (!clockHoldN) begin
			s1 <= pinBeat;
			s2 <= s1;
			if (s1.wr) begin
				{byteParityLinesIn, dataIn} <= s1.word;
			end else begin
				{byteParityLinesIn, dataIn} <= ~{byteParityLinesIn, dataIn};
			end
		end
	end

	always @(negedge ref_clk) begin
		if (rst_n) begin
			tb_top.check("pinDrive",
				36'({byteParityLinesOe, dataOe}),
				36'({2{s2.rd && !outputEnableN}}));
			if (s2.rd && !outputEnableN) begin
				tb_top.check("readWord",
					{byteParityLinesOut, dataOut}, s2.word);
			end
		end
	end
endmodule

/* tb_top.sv */
// Self-checking bench of the burst SRAM cycle decoder.
// Assumes the design package and the controller model are compiled first.
`timescale 1ns/10ps
module tb_top;
	// ------------------------------------------------------------
	// Signals, reference memory and checks
	// ------------------------------------------------------------
	sync_burst_sram_pkg::cmd_s cmd;
	logic        ref_clk, rst_n, clockHoldN, outputEnableN;
	logic        sleepRequest, burstOrder, dataOe, parOe, sleeping;
	logic [7:0]  address, bBase;
	logic [31:0] dataIn, dataOut;
	logic [3:0]  parIn, parOut;
	logic [35:0] mem [256];
	logic [31:0] lfsrQ = 32'h365a;
	logic [1:0]  bType, bN;
	int          numErrors, compares;

	sync_burst_sram_cycle_decode #(.ADDR_W(8)) uut (.ref_clk(ref_clk),
		.rst_n(rst_n), .cmd(cmd), .address(address), .clockHoldN(clockHoldN),
		.outputEnableN(outputEnableN), .sleepRequest(sleepRequest),
		.burstOrder(burstOrder), .dataIn(dataIn), .dataOut(dataOut),
		.dataOe(dataOe), .byteParityLinesIn(parIn),
		.byteParityLinesOut(parOut), .byteParityLinesOe(parOe),
		.sleeping(sleeping));

	sram_ctrl_model u_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd),
		.address(address), .clockHoldN(clockHoldN), .dataIn(dataIn),
		.byteParityLinesIn(parIn), .dataOut(dataOut),
		.byteParityLinesOut(parOut), .dataOe(dataOe),
		.byteParityLinesOe(parOe), .outputEnableN(outputEnableN));

	task automatic check(input string name, input logic [35:0] seen,
		input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
		return lfsrQ;
	endfunction

	// ------------------------------------------------------------
	// Beats: 0 deselect, 1 read, 2 write, 3 continue, 4 stall, 5 ignored
	// ------------------------------------------------------------
	task automatic send(input int kind, input logic [3:0] lanes,
		input logic [7:0] a);
		sync_burst_sram_pkg::cmd_s c;
		logic [31:0] r;
		logic [35:0] w;
		logic [7:0]  ea;
		r = rnd();
		w = {r[31:28], rnd()};
		c = r[8:0];
		c.byteLaneSelectN = lanes;
		if (kind == 4) begin
			u_ctrl.issue(c, a, 1'b1, '0);
		end else begin
			c.advanceOrLoad = (kind == 3);
			if (kind != 3) begin
				c.writeStrobeN = (kind == 1);
				c[8:6] = (kind != 0) ? 3'b010
					: (r[8:6] == 3'b010) ? 3'b110 : r[8:6];
				if (kind != 5) begin
					bType = kind[1:0];
					bBase = a;
					bN = 2'b00;
				end
			end else begin
				bN++;
			end
			ea = {bBase[7:2], burstOrder ? bBase[1:0] ^ bN
				: bBase[1:0] + bN};
			if (bType == 2'd1) w = mem[ea];
			if (bType == 2'd2 && kind != 5) begin
				for (int i = 0; i < 4; i++) begin
					if (!lanes[i]) begin
						mem[ea][8*i+:8] = w[8*i+:8];
						mem[ea][32+i] = w[32+i];
					end
				end
			end
			if (kind == 5) u_ctrl.issue(c, a, 1'b0, '0);
			else u_ctrl.issue(c, a, 1'b0, {bType == 2'd1, bType == 2'd2, w});
		end
		outputEnableN <= r[20];
	endtask

	task automatic traffic(input int n);
		logic [31:0] r;
		int k [8] = '{0, 1, 1, 2, 2, 3, 3, 4};
		for (int j = 0; j < n; j++) begin
			r = rnd();
			send(k[r[2:0]], r[7:4], r[15:8]);
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial begin
		#(50 * 5000);
		numErrors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		outputEnableN = 1'b0;
		sleepRequest = 1'b0;
		burstOrder = 1'b0;
		repeat (11) @(posedge ref_clk);
		@(negedge ref_clk);
		check("resetPins", {2'b00, parOe, dataOe, dataOut}, 36'h0);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 256; a += 4) begin
			send(2, 4'h0, a[7:0]);
			repeat (3) send(3, 4'h0, 8'h00);
		end
		for (int i = 0; i < 16; i++) begin
			send(2, i[3:0], 8'h40);
			send(1, 4'hf, 8'h40);
		end
		send(2, 4'hf, 8'h44);
		send(3, 4'h0, 8'h00);
		send(4, 4'h0, 8'h00);
		send(3, 4'hf, 8'h00);
		send(3, 4'h6, 8'h00);
		send(1, 4'h0, 8'h44);
		repeat (5) send(3, 4'h0, 8'h00);
		send(0, 4'h0, 8'h00);
		send(3, 4'h0, 8'h00);
		traffic(500);
		repeat (3) send(0, 4'hf, 8'h00);
		burstOrder <= 1'b1;
		repeat (4) send(0, 4'hf, 8'h00);
		traffic(500);
		repeat (3) send(0, 4'hf, 8'h00);
		sleepRequest <= 1'b1;
		for (int j = 0; j < 10 && sleeping !== 1'b1; j++) send(0, 4'hf, 8'h00);
		check("sleepIn", 36'(sleeping), 36'h1);
		send(5, 4'h0, 8'h40);
		sleepRequest <= 1'b0;
		for (int j = 0; j < 10 && sleeping !== 1'b0; j++) send(0, 4'hf, 8'h00);
		check("sleepOut", 36'(sleeping), 36'h0);
		repeat (4) send(0, 4'hf, 8'h00);
		send(1, 4'h0, 8'h40);
		traffic(200);
		repeat (4) send(0, 4'hf, 8'h00);
		report_and_stop();
	end
endmodule
